//--- logic/tocp_pkg.sv
// Package with register map, field positions, reset values and encodings of the compare timer.
package tocp_pkg;

    // ------------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------------
    localparam int ADDR_W = 4;
    localparam logic [3:0] OFS_STATUS = 4'h0;
    localparam logic [3:0] OFS_CNT_HI = 4'h1;
    localparam logic [3:0] OFS_CNT_LO = 4'h2;
    localparam logic [3:0] OFS_MOD_HI = 4'h3;
    localparam logic [3:0] OFS_MOD_LO = 4'h4;
    localparam logic [3:0] OFS_CH0_CTRL = 4'h5;
    localparam logic [3:0] OFS_CH0_HI = 4'h6;
    localparam logic [3:0] OFS_CH0_LO = 4'h7;
    localparam logic [3:0] OFS_CH1_CTRL = 4'h8;
    localparam logic [3:0] OFS_CH1_HI = 4'h9;
    localparam logic [3:0] OFS_CH1_LO = 4'hA;

    // ------------------------------------------------------------------
    // Status and control fields
    // ------------------------------------------------------------------
    localparam int B_OVF_FLAG = 7;
    localparam int B_OVF_IE = 6;
    localparam int B_HALT = 5;
    localparam int B_CLEAR = 4;
    localparam int PS_MSB = 2;
    localparam int PS_LSB = 0;

    // ------------------------------------------------------------------
    // Channel control fields
    // ------------------------------------------------------------------
    localparam int B_CH_FLAG = 7;
    localparam int B_CH_IE = 6;
    localparam int B_LINK = 5;
    localparam int ACT_MSB = 4;
    localparam int ACT_LSB = 3;
    localparam int B_TOV = 2;

    // ------------------------------------------------------------------
    // Reset values and encodings
    // ------------------------------------------------------------------
    localparam logic [7:0] STATUS_RST = 8'h20;
    localparam logic [7:0] CH_CTRL_RST = 8'h00;
    localparam logic [15:0] MOD_RST = 16'hFFFF;
    localparam logic [15:0] CH_VAL_RST = 16'h0000;
    localparam logic [1:0] ACT_NONE = 2'h0;
    localparam logic [1:0] ACT_TOGGLE = 2'h1;
    localparam logic [1:0] ACT_CLEAR = 2'h2;
    localparam logic [1:0] ACT_SET = 2'h3;
    localparam logic [2:0] PS_EXT = 3'h7;
    localparam int PS_DIV_W = 6;

endpackage : tocp_pkg

//--- logic/tocp_prescaler.sv
// Prescaler that turns the bus clock or the external timer clock pin into count ticks.
`timescale 1ns/100ps
module tocp_prescaler #(
    parameter bit HAS_EXT_CLK = 1'b1
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Control
    input wire logic halt,
    input wire logic clear,
    input wire logic [2:0] prescale_select,
    input wire logic external_timer_clock_pin,
    // Tick out
    output logic tick
);

    logic [tocp_pkg::PS_DIV_W-1:0] div_q, div_d;
    logic ext_q, ext_d;
    logic [tocp_pkg::PS_DIV_W-1:0] mask;

    always_comb begin
        div_d = div_q;
        ext_d = external_timer_clock_pin;
        mask = tocp_pkg::PS_DIV_W'(6'h3F >> (3'd6 - prescale_select));
        tick = 1'b0;
        if (clear) begin
            div_d = '0;
        end else if (!halt) begin
            div_d = div_q + 1'b1;
            if (prescale_select == tocp_pkg::PS_EXT) begin
                tick = HAS_EXT_CLK && external_timer_clock_pin && !ext_q;
            end else begin
                tick = (div_q & mask) == mask;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            div_q <= '0;
            ext_q <= 1'b0;
        end else begin
            div_q <= div_d;
            ext_q <= ext_d;
        end
    end

endmodule : tocp_prescaler

//--- logic/tocp_timer.sv
// Top of the 16-bit compare timer: counter, two compare channels, buffering and register port.
//
// How it works
// - On count equal to channel value, set, clear or toggle pin; flag interrupt.
// - Unbuffered channel writes take effect at once; a passed value misses this period.
// - Compare flag rises at the match; overflow flag rises at the wrap.
// - Link bit in channel 0 control pairs both channels onto channel 0 pin.
// - Linked: channel 0 value first; last written pair takes over at overflow.
// - Linked: channel 1 control ignored and channel 1 pin released.
// - Toggle-on-overflow flips the pin when count wraps at the modulo value.
// - Pulse width runs from overflow to the channel compare match.
// - Halt bit freezes the counter; reset sets it.
// - Clear bit zeroes counter and prescaler, reads zero, self clears.
// - Halt and clear written together leave the counter stopped at zero.
// - Prescale select divides by 1 to 64, code 7 uses external clock.
// - Reading count high byte latches low byte until low byte is read.
// - Count bytes clear on reset and on the clear bit.
`timescale 1ns/100ps
module tocp_timer #(
    parameter bit HAS_EXT_CLK = 1'b1
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Register port
    input wire logic [tocp_pkg::ADDR_W-1:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [7:0] rdata,
    // Pins
    input wire logic external_timer_clock_pin,
    output logic channel0_pin,
    output logic channel0_pin_oe,
    output logic channel1_pin,
    output logic channel1_pin_oe,
    // Interrupt requests
    output logic ovf_irq,
    output logic ch0_irq,
    output logic ch1_irq
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    logic [7:0] status_q, status_d;
    logic [15:0] cnt_q, cnt_d;
    logic [15:0] mod_q, mod_d;
    logic [7:0] ch_ctrl_q [2];
    logic [7:0] ch_ctrl_d [2];
    logic [15:0] ch_val_q [2];
    logic [15:0] ch_val_d [2];
    logic [1:0] pin_q, pin_d;
    logic [1:0] oe_q, oe_d;
    logic active_q, active_d;
    logic pending_q, pending_d;
    logic [7:0] lat_q, lat_d;
    logic lat_valid_q, lat_valid_d;
    logic [7:0] rdata_q, rdata_d;
    logic [2:0] irq_q, irq_d;

    logic tick;
    logic clear_wr;
    logic at_mod;
    logic ovf_evt;
    logic linked;
    logic [15:0] cnt_inc;
    logic [1:0] match;
    logic [1:0] ch_en;

    assign clear_wr = wr_en && addr == tocp_pkg::OFS_STATUS && wdata[tocp_pkg::B_CLEAR];
    assign linked = ch_ctrl_q[0][tocp_pkg::B_LINK];
    assign at_mod = cnt_q == mod_q;
    assign cnt_inc = at_mod ? 16'h0000 : cnt_q + 16'h0001;
    assign ovf_evt = tick && !clear_wr && at_mod;

    // ------------------------------------------------------------------
    // Prescaler
    // ------------------------------------------------------------------
    tocp_prescaler #(
        .HAS_EXT_CLK(HAS_EXT_CLK)
    ) u_prescaler (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .halt(status_q[tocp_pkg::B_HALT]),
        .clear(clear_wr),
        .prescale_select(status_q[tocp_pkg::PS_MSB:tocp_pkg::PS_LSB]),
        .external_timer_clock_pin(external_timer_clock_pin),
        .tick(tick)
    );

    // ------------------------------------------------------------------
    // Per-channel compare
    // ------------------------------------------------------------------
    // Channel 0 takes its value from whichever pair is active when linked; its
    // control register stays in charge of the pin in both modes.
    for (genvar c = 0; c < 2; c++) begin : g_cmp
        logic [15:0] eff_val;
        assign eff_val = (c == 0 && linked && active_q) ? ch_val_q[1] : ch_val_q[c];
        assign ch_en[c] = (c == 0) || !linked;
        assign match[c] = tick && !clear_wr && ch_en[c] && cnt_inc == eff_val;
    end

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    always_comb begin
        status_d = status_q;
        cnt_d = cnt_q;
        mod_d = mod_q;
        ch_ctrl_d = ch_ctrl_q;
        ch_val_d = ch_val_q;
        pin_d = pin_q;
        oe_d = oe_q;
        active_d = active_q;
        pending_d = pending_q;
        lat_d = lat_q;
        lat_valid_d = lat_valid_q;
        rdata_d = 8'h00;

        // Register writes. Flags clear on a written 0 and keep a written 1.
        if (wr_en) begin
            case (addr)
                tocp_pkg::OFS_STATUS: begin
                    status_d = {status_q[tocp_pkg::B_OVF_FLAG] & wdata[tocp_pkg::B_OVF_FLAG],
                                wdata[6:5], 1'b0, 1'b0, wdata[2:0]};
                end
                tocp_pkg::OFS_MOD_HI: mod_d[15:8] = wdata;
                tocp_pkg::OFS_MOD_LO: mod_d[7:0] = wdata;
                tocp_pkg::OFS_CH0_CTRL: begin
                    ch_ctrl_d[0] = {ch_ctrl_q[0][7] & wdata[7], wdata[6:2], 2'b00};
                end
                tocp_pkg::OFS_CH1_CTRL: begin
                    ch_ctrl_d[1] = {ch_ctrl_q[1][7] & wdata[7], 1'b0, 1'b0, wdata[4:2], 2'b00};
                    ch_ctrl_d[1][tocp_pkg::B_CH_IE] = wdata[tocp_pkg::B_CH_IE];
                end
                tocp_pkg::OFS_CH0_HI: ch_val_d[0][15:8] = wdata;
                tocp_pkg::OFS_CH0_LO: begin
                    ch_val_d[0][7:0] = wdata;
                    pending_d = 1'b0;
                end
                tocp_pkg::OFS_CH1_HI: ch_val_d[1][15:8] = wdata;
                tocp_pkg::OFS_CH1_LO: begin
                    ch_val_d[1][7:0] = wdata;
                    pending_d = 1'b1;
                end
                default: ;
            endcase
        end

        // Counter. Clear wins over a tick; halt is applied in the prescaler.
        if (clear_wr) begin
            cnt_d = 16'h0000;
            lat_d = 8'h00;
            lat_valid_d = 1'b0;
        end else if (tick) begin
            cnt_d = cnt_inc;
        end

        // Pairing swaps only at overflow so the active pair never changes mid period.
        if (!linked) begin
            active_d = 1'b0;
        end else if (ovf_evt) begin
            active_d = pending_d;
        end

        // Flags: hardware set wins over a software clear in the same cycle.
        if (ovf_evt) begin
            status_d[tocp_pkg::B_OVF_FLAG] = 1'b1;
        end
        for (int c = 0; c < 2; c++) begin
            if (match[c]) begin
                ch_ctrl_d[c][tocp_pkg::B_CH_FLAG] = 1'b1;
            end
            // Overflow toggle first, so a match on the wrap count sets the final level.
            if (ovf_evt && ch_en[c] && ch_ctrl_q[c][tocp_pkg::B_TOV]) begin
                pin_d[c] = !pin_d[c];
            end
            if (match[c]) begin
                case (ch_ctrl_q[c][tocp_pkg::ACT_MSB:tocp_pkg::ACT_LSB])
                    tocp_pkg::ACT_TOGGLE: pin_d[c] = !pin_q[c];
                    tocp_pkg::ACT_CLEAR: pin_d[c] = 1'b0;
                    tocp_pkg::ACT_SET: pin_d[c] = 1'b1;
                    default: ;
                endcase
            end
            oe_d[c] = ch_en[c] && (ch_ctrl_q[c][tocp_pkg::ACT_MSB:tocp_pkg::ACT_LSB]
                      != tocp_pkg::ACT_NONE || ch_ctrl_q[c][tocp_pkg::B_TOV]);
        end

        // Reads, with the low byte held after a high byte read.
        if (rd_en) begin
            case (addr)
                tocp_pkg::OFS_STATUS: rdata_d = status_q;
                tocp_pkg::OFS_CNT_HI: begin
                    rdata_d = cnt_q[15:8];
                    if (!lat_valid_q && !clear_wr) begin
                        lat_d = cnt_q[7:0];
                        lat_valid_d = 1'b1;
                    end
                end
                tocp_pkg::OFS_CNT_LO: begin
                    rdata_d = lat_valid_q ? lat_q : cnt_q[7:0];
                    lat_valid_d = 1'b0;
                end
                tocp_pkg::OFS_MOD_HI: rdata_d = mod_q[15:8];
                tocp_pkg::OFS_MOD_LO: rdata_d = mod_q[7:0];
                tocp_pkg::OFS_CH0_CTRL: rdata_d = ch_ctrl_q[0];
                tocp_pkg::OFS_CH0_HI: rdata_d = ch_val_q[0][15:8];
                tocp_pkg::OFS_CH0_LO: rdata_d = ch_val_q[0][7:0];
                tocp_pkg::OFS_CH1_CTRL: rdata_d = ch_ctrl_q[1];
                tocp_pkg::OFS_CH1_HI: rdata_d = ch_val_q[1][15:8];
                tocp_pkg::OFS_CH1_LO: rdata_d = ch_val_q[1][7:0];
                default: rdata_d = 8'h00;
            endcase
        end

        irq_d[0] = status_d[tocp_pkg::B_OVF_FLAG] && status_d[tocp_pkg::B_OVF_IE];
        irq_d[1] = ch_ctrl_d[0][tocp_pkg::B_CH_FLAG] && ch_ctrl_d[0][tocp_pkg::B_CH_IE];
        irq_d[2] = ch_ctrl_d[1][tocp_pkg::B_CH_FLAG] && ch_ctrl_d[1][tocp_pkg::B_CH_IE] && !linked;
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            status_q <= tocp_pkg::STATUS_RST;
            cnt_q <= 16'h0000;
            mod_q <= tocp_pkg::MOD_RST;
            ch_ctrl_q[0] <= tocp_pkg::CH_CTRL_RST;
            ch_ctrl_q[1] <= tocp_pkg::CH_CTRL_RST;
            ch_val_q[0] <= tocp_pkg::CH_VAL_RST;
            ch_val_q[1] <= tocp_pkg::CH_VAL_RST;
            pin_q <= 2'b00;
            oe_q <= 2'b00;
            active_q <= 1'b0;
            pending_q <= 1'b0;
            lat_q <= 8'h00;
            lat_valid_q <= 1'b0;
            rdata_q <= 8'h00;
            irq_q <= 3'b000;
        end else begin
            status_q <= status_d;
            cnt_q <= cnt_d;
            mod_q <= mod_d;
            ch_ctrl_q <= ch_ctrl_d;
            ch_val_q <= ch_val_d;
            pin_q <= pin_d;
            oe_q <= oe_d;
            active_q <= active_d;
            pending_q <= pending_d;
            lat_q <= lat_d;
            lat_valid_q <= lat_valid_d;
            rdata_q <= rdata_d;
            irq_q <= irq_d;
        end
    end

    assign rdata = rdata_q;
    assign channel0_pin = pin_q[0];
    assign channel1_pin = pin_q[1];
    assign channel0_pin_oe = oe_q[0];
    assign channel1_pin_oe = oe_q[1];
    assign ovf_irq = irq_q[0];
    assign ch0_irq = irq_q[1];
    assign ch1_irq = irq_q[2];

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    sequence s_stop_clear;
        wr_en && addr == tocp_pkg::OFS_STATUS && wdata[tocp_pkg::B_HALT] &&
            wdata[tocp_pkg::B_CLEAR];
    endsequence

    sequence s_quiet2;
        !wr_en [*2];
    endsequence

    chk_halt_freezes: assert property (
        status_q[tocp_pkg::B_HALT] && !clear_wr |=> cnt_q == $past(cnt_q))
        else $error("counter moved while halted");

    chk_clear_zeros: assert property (
        clear_wr |=> cnt_q == 16'h0000 && !status_q[tocp_pkg::B_CLEAR])
        else $error("clear did not zero the counter");

    chk_stop_at_zero: assert property (
        s_stop_clear ##1 s_quiet2 |-> cnt_q == 16'h0000)
        else $error("counter left zero after halt with clear");

    chk_wrap_overflow: assert property (
        ovf_evt |=> cnt_q == 16'h0000 && status_q[tocp_pkg::B_OVF_FLAG])
        else $error("wrap did not zero counter and flag overflow");

    chk_match_flag: assert property (
        match[0] |=> ch_ctrl_q[0][tocp_pkg::B_CH_FLAG] && cnt_q == $past(cnt_inc))
        else $error("compare flag missing after match");

    chk_set_action: assert property (
        match[0] && ch_ctrl_q[0][tocp_pkg::ACT_MSB:tocp_pkg::ACT_LSB] == tocp_pkg::ACT_SET
        |=> channel0_pin)
        else $error("set action did not raise the pin");

    chk_link_frees: assert property (
        linked |-> !match[1] ##1 !channel1_pin_oe)
        else $error("channel 1 still active while linked");

    chk_pair_swap: assert property (
        linked && ovf_evt && !wr_en |=> active_q == $past(pending_q))
        else $error("pair did not swap at overflow");

    chk_low_latch: assert property (
        rd_en && addr == tocp_pkg::OFS_CNT_HI && !lat_valid_q && !clear_wr
        |=> lat_valid_q && lat_q == $past(cnt_q[7:0]))
        else $error("low byte not latched on high read");

    chk_reset_state: assert property (
        $rose(rst_n) |-> status_q == tocp_pkg::STATUS_RST && cnt_q == 16'h0000)
        else $error("reset state wrong");

endmodule : tocp_timer

//--- verification/tocp_timer_bench.sv
// Self-checking bench for the compare timer: registers, counter, prescaler, pins and links.
`timescale 1ns/100ps
module timer_output_compare_pwm_bench;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00;
    logic wr_en = 1'b0;
    logic rd_en = 1'b0;
    logic [7:0] rdata;
    logic ext_clk = 1'b0;
    logic [1:0] ediv = 2'b00;
    logic ch0_pin, ch0_oe, ch1_pin, ch1_oe, ovf_irq, ch0_irq, ch1_irq;
    int mismatches = 0;
    int checked = 0;
    int cycles = 0;
    int seed = 32'hd707_8048;
    int hc;
    logic [8:0] notes[$];
    logic [8:0] note;
    logic [7:0] seen;
    logic [7:0] v;
    logic [3:0] ra;
    logic rd_p = 1'b0;
    logic [1:0] acts [4] = '{tocp_pkg::ACT_SET, tocp_pkg::ACT_CLEAR, tocp_pkg::ACT_TOGGLE,
                             tocp_pkg::ACT_NONE};
    logic [7:0] hexp [4] = '{8'd100, 8'd0, 8'd50, 8'd0};

    always #25 ref_clk = ~ref_clk;

    tocp_timer #(.HAS_EXT_CLK(1'b1)) DUT (
        .ref_clk(ref_clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr_en(wr_en),
        .rd_en(rd_en), .rdata(rdata), .external_timer_clock_pin(ext_clk),
        .channel0_pin(ch0_pin), .channel0_pin_oe(ch0_oe), .channel1_pin(ch1_pin),
        .channel1_pin_oe(ch1_oe), .ovf_irq(ovf_irq), .ch0_irq(ch0_irq), .ch1_irq(ch1_irq)
    );

    // ------------------------------------------------------------------
    // Checking and closing
    // ------------------------------------------------------------------
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : final_report

    // Read data stands only in the cycle after the strobe, so it is taken there.
    always @(posedge ref_clk) begin
        if (rd_p) begin
            seen = rdata;
            note = notes.pop_front();
            if (note[8]) chk(rdata, note[7:0]);
        end
        rd_p <= rd_en;
    end

    always @(posedge ref_clk) begin
        cycles++;
        if (cycles > 20000) begin
            mismatches++;
            final_report();
        end
    end

    // External count clock with a period of four bus cycles.
    always @(posedge ref_clk) begin
        ediv <= ediv + 2'd1;
        ext_clk <= ediv[1];
    end

    // ------------------------------------------------------------------
    // Bus tasks
    // ------------------------------------------------------------------
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        wr_en <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge ref_clk);
        wr_en <= 1'b0;
    endtask : wr

    // Strobes sit three cycles apart when reads follow each other.
    task automatic rd(input logic [3:0] a, input logic cmp, input logic [7:0] e);
        @(posedge ref_clk);
        rd_en <= 1'b1;
        addr <= a;
        notes.push_back({cmp, e});
        @(posedge ref_clk);
        rd_en <= 1'b0;
        @(posedge ref_clk);
        #1;
    endtask : rd

    task automatic idle(input int n);
        repeat (n) @(posedge ref_clk);
    endtask : idle

    task automatic high_count(input logic sel, input int len, output int cnt);
        cnt = 0;
        repeat (len) begin
            @(posedge ref_clk);
            if ((sel ? ch1_pin : ch0_pin) === 1'b1) cnt++;
        end
    endtask : high_count

    // Waits a bounded time for an interrupt line, as a handler would be entered.
    task automatic wait_for(input logic sel);
        int n;
        n = 0;
        @(posedge ref_clk);
        while ((sel ? ch0_irq : ovf_irq) !== 1'b1 && n < 30) begin
            @(posedge ref_clk);
            n++;
        end
        chk(8'(sel ? ch0_irq : ovf_irq), 8'h01);
    endtask : wait_for

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        repeat (12) @(posedge ref_clk);
        rst_n <= 1'b1;
        rd(tocp_pkg::OFS_STATUS, 1'b1, 8'h20);
        rd(tocp_pkg::OFS_CNT_HI, 1'b1, 8'h00);
        rd(tocp_pkg::OFS_MOD_HI, 1'b1, 8'hFF);
        rd(tocp_pkg::OFS_CH0_CTRL, 1'b1, 8'h00);
        idle(20);
        rd(tocp_pkg::OFS_CNT_LO, 1'b1, 8'h00);
        for (int i = 0; i < 4; i++) begin
            ra = 4'hB + 4'($random(seed) & 3);
            wr(ra, 8'($random(seed)));
            rd(ra, 1'b1, 8'h00);
        end
        // Tick count over a 64-cycle window for every prescale code.
        for (int ps = 0; ps < 8; ps++) begin
            wr(tocp_pkg::OFS_STATUS, 8'(ps));
            rd(tocp_pkg::OFS_CNT_LO, 1'b0, 8'h00);
            v = seen;
            idle(61);
            rd(tocp_pkg::OFS_CNT_LO, 1'b0, 8'h00);
            chk(seen - v, (ps == 7) ? 8'd16 : 8'(64 >> ps));
        end
        wr(tocp_pkg::OFS_STATUS, 8'h00);
        rd(tocp_pkg::OFS_CNT_LO, 1'b0, 8'h00);
        v = seen;
        rd(tocp_pkg::OFS_CNT_HI, 1'b0, 8'h00);
        idle(5);
        rd(tocp_pkg::OFS_CNT_HI, 1'b0, 8'h00);
        rd(tocp_pkg::OFS_CNT_LO, 1'b1, v + 8'd3);
        rd(tocp_pkg::OFS_CNT_LO, 1'b1, v + 8'd17);
        wr(tocp_pkg::OFS_STATUS, 8'h20);
        rd(tocp_pkg::OFS_CNT_LO, 1'b0, 8'h00);
        idle(20);
        rd(tocp_pkg::OFS_CNT_LO, 1'b1, seen);
        wr(tocp_pkg::OFS_STATUS, 8'h00);
        wr(tocp_pkg::OFS_STATUS, 8'h30);
        idle(10);
        rd(tocp_pkg::OFS_CNT_HI, 1'b1, 8'h00);
        rd(tocp_pkg::OFS_CNT_LO, 1'b1, 8'h00);
        rd(tocp_pkg::OFS_STATUS, 1'b1, 8'h20);
        wr(tocp_pkg::OFS_STATUS, 8'h00);
        idle(10);
        wr(tocp_pkg::OFS_STATUS, 8'h10);
        rd(tocp_pkg::OFS_STATUS, 1'b1, 8'h00);
        rd(tocp_pkg::OFS_CNT_LO, 1'b0, 8'h00);
        chk(8'(seen < 8'd8), 8'h01);
        // Pulse-width output: period of ten ticks, high from wrap to count three.
        wr(tocp_pkg::OFS_STATUS, 8'h30);
        wr(tocp_pkg::OFS_MOD_HI, 8'h00);
        wr(tocp_pkg::OFS_MOD_LO, 8'h09);
        wr(tocp_pkg::OFS_CH0_LO, 8'h03);
        wr(tocp_pkg::OFS_CH0_CTRL, 8'h54);
        wr(tocp_pkg::OFS_STATUS, 8'h00);
        idle(30);
        high_count(1'b0, 100, hc);
        chk(8'(hc), 8'd30);
        chk(8'(ch0_oe), 8'h01);
        chk(8'(ch0_irq), 8'h01);
        chk(8'(ovf_irq), 8'h00);
        rd(tocp_pkg::OFS_STATUS, 1'b1, 8'h80);
        wr(tocp_pkg::OFS_STATUS, 8'h40);
        idle(12);
        chk(8'(ovf_irq), 8'h01);
        wr(tocp_pkg::OFS_STATUS, 8'h00);
        idle(2);
        chk(8'(ovf_irq), 8'h00);
        wr(tocp_pkg::OFS_CH1_LO, 8'h05);
        for (int k = 0; k < 4; k++) begin
            wr(tocp_pkg::OFS_CH1_CTRL, {3'b000, acts[k], 3'b000});
            idle(12);
            high_count(1'b1, 100, hc);
            if (k < 3) chk(8'(hc), hexp[k]);
            chk(8'(ch1_oe), (k < 3) ? 8'h01 : 8'h00);
        end
        // Linked pair: channel 1 control is ignored and its pin is let go.
        wr(tocp_pkg::OFS_CH1_CTRL, 8'h58);
        wr(tocp_pkg::OFS_CH0_LO, 8'h03);
        wr(tocp_pkg::OFS_CH0_CTRL, 8'h34);
        idle(30);
        high_count(1'b0, 100, hc);
        chk(8'(hc), 8'd30);
        chk(8'(ch1_oe), 8'h00);
        chk(8'(ch1_irq), 8'h00);
        wr(tocp_pkg::OFS_CH1_HI, 8'h00);
        wr(tocp_pkg::OFS_CH1_LO, 8'h06);
        idle(30);
        high_count(1'b0, 100, hc);
        chk(8'(hc), 8'd60);
        wr(tocp_pkg::OFS_CH0_LO, 8'h02);
        idle(30);
        high_count(1'b0, 100, hc);
        chk(8'(hc), 8'd20);
        // Unlinked again: fixed pin actions, then unbuffered updates from the handlers.
        wr(tocp_pkg::OFS_CH0_CTRL, 8'h10);
        idle(12);
        chk(8'(ch0_pin), 8'h00);
        wr(tocp_pkg::OFS_CH0_CTRL, 8'h18);
        idle(12);
        chk(8'(ch0_pin), 8'h01);
        wr(tocp_pkg::OFS_CH0_CTRL, 8'h54);
        wr(tocp_pkg::OFS_STATUS, 8'h40);
        wait_for(1'b0);
        wr(tocp_pkg::OFS_CH0_LO, 8'h06);
        idle(30);
        high_count(1'b0, 100, hc);
        chk(8'(hc), 8'd60);
        wr(tocp_pkg::OFS_CH0_CTRL, 8'h54);
        wait_for(1'b1);
        wr(tocp_pkg::OFS_CH0_LO, 8'h03);
        idle(30);
        high_count(1'b0, 100, hc);
        chk(8'(hc), 8'd30);
        final_report();
    end
endmodule : timer_output_compare_pwm_bench
